// File: core/quad_dac_ctrl.sv
// Control and power/alert registers of a quad serial-input converter
`timescale 1ns/100ps
`default_nettype none
`include "quad_dac_ctrl_map.svh"

// How it works
// - No-op control write leaves everything unchanged
// - Clear loads clear code, updates all outputs
// - Load moves input data to all outputs
// - Serial-output-disable set stops driving serial output
// - Clamp mode: overcurrent never powers channel down
// - Clamp off: overcurrent powers channel down
// - Overtemp enable bit arms thermal shutdown
// - Clear-level select picks zero or midscale/negative
// - Register select 010 means power register
// - Power register bit layout as documented
// - Channel power-up bit one means normal mode
// - Auto power-down clears channel power-up bit
// - Reference power-up bit runs internal reference
// - Overtemp powers down all channels, sets alert
// - Overcurrent sets read-only per-channel alert
// - Select 011 is control, channel codes decode
// - 24-bit frames, data sampled on clock fall
// - Clamp mode clears alert when fault removed
module quad_dac_ctrl #(
    parameter int CHANNELS = 4
) (
    // Clock, reset, enable
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Serial link pins
    input  wire logic                  sclk,
    input  wire logic                  sync_n,
    input  wire logic                  sdin,
    output logic                       sdo,
    output logic                       sdo_oe,
    // Analog-side fault inputs
    input  wire logic [CHANNELS-1:0]   overcurrent_in,
    input  wire logic                  overtemp_in,
    // Range polarity from range registers
    input  wire logic [CHANNELS-1:0]   chan_range_bipolar,
    // Converter-side controls
    output logic                       dac_clear,
    output logic                       dac_load,
    output quad_dac_ctrl_pkg::clear_kind_t clear_kind [CHANNELS],
    output logic [CHANNELS-1:0]        chan_power_up,
    output logic                       reference_power_up,
    output logic                       clamp_enable,
    output logic                       overtemp_shutdown_enable,
    output logic                       clear_level_select
);

    // ==========================================================
    // Pin synchronisers
    logic [1:0]              sclk_sync_q;
    logic [1:0]              sync_sync_q;
    logic [1:0]              sdin_sync_q;
    logic [CHANNELS-1:0]     oc_meta_q;
    logic [CHANNELS-1:0]     oc_q;
    logic [1:0]              ot_sync_q;
    logic                    sclk_prev_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sclk_sync_q <= 2'h0;
            sync_sync_q <= 2'h3;
            sdin_sync_q <= 2'h0;
            oc_meta_q   <= '0;
            oc_q        <= '0;
            ot_sync_q   <= 2'h0;
            sclk_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            sclk_sync_q <= {sclk_sync_q[0], sclk};
            sync_sync_q <= {sync_sync_q[0], sync_n};
            sdin_sync_q <= {sdin_sync_q[0], sdin};
            oc_meta_q   <= overcurrent_in;
            oc_q        <= oc_meta_q;
            ot_sync_q   <= {ot_sync_q[0], overtemp_in};
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    logic sclk_fall;
    logic sclk_rise;
    logic sync_low;
    logic ot_now;

    assign sclk_fall = sclk_prev_q & ~sclk_sync_q[1];
    assign sclk_rise = ~sclk_prev_q & sclk_sync_q[1];
    assign sync_low  = ~sync_sync_q[1];
    assign ot_now    = ot_sync_q[1];

    // ==========================================================
    // Frame receiver
    quad_dac_ctrl_pkg::frame_state_t  fr_q;
    logic [`FRAME_CNT_W-1:0]          bit_cnt_q;
    logic [`FRAME_BITS-1:0]           rx_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            fr_q      <= quad_dac_ctrl_pkg::FR_IDLE;
            bit_cnt_q <= '0;
            rx_q      <= '0;
        end
        else if (ce)
        begin
            case (fr_q)
                quad_dac_ctrl_pkg::FR_IDLE:
                begin
                    bit_cnt_q <= '0;
                    if (sync_low)
                        fr_q <= quad_dac_ctrl_pkg::FR_SHIFT;
                end
                quad_dac_ctrl_pkg::FR_SHIFT:
                begin
                    if (!sync_low)
                        fr_q <= quad_dac_ctrl_pkg::FR_IDLE;
                    else if (sclk_fall)
                    begin
                        rx_q      <= {rx_q[`FRAME_BITS-2:0], sdin_sync_q[1]};
                        bit_cnt_q <= bit_cnt_q + `FRAME_CNT_W'(1);
                        if (bit_cnt_q == `FRAME_CNT_W'(`FRAME_BITS - 1))
                            fr_q <= quad_dac_ctrl_pkg::FR_DONE;
                    end
                end
                quad_dac_ctrl_pkg::FR_DONE:
                begin
                    // Wait for the frame to close; extra clocks are ignored
                    if (!sync_low)
                        fr_q <= quad_dac_ctrl_pkg::FR_IDLE;
                end
                default:
                    fr_q <= quad_dac_ctrl_pkg::FR_IDLE;
            endcase
        end
    end

    // One-cycle strobe when the 24th bit lands
    logic frame_done;
    assign frame_done = (fr_q == quad_dac_ctrl_pkg::FR_SHIFT) && sync_low && sclk_fall
                        && (bit_cnt_q == `FRAME_CNT_W'(`FRAME_BITS - 1));

    logic [`FRAME_BITS-1:0] frame;
    logic                   f_read;
    logic [2:0]             f_reg;
    logic [2:0]             f_chan;
    logic [15:0]            f_data;

    assign frame  = {rx_q[`FRAME_BITS-2:0], sdin_sync_q[1]};
    assign f_read = frame[`FRAME_RW_BIT];
    assign f_reg  = frame[`FRAME_REG_HI:`FRAME_REG_LO];
    assign f_chan = frame[`FRAME_CHAN_HI:`FRAME_CHAN_LO];
    assign f_data = frame[`FRAME_DATA_HI:0];
    logic wr_ctrl;
    logic wr_power;

    assign wr_ctrl  = frame_done && !f_read && (f_reg == `REG_SEL_CONTROL);
    assign wr_power = frame_done && !f_read && (f_reg == `REG_SEL_POWER);

    // ==========================================================
    // Control functions
    logic [3:0] cfg_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cfg_q <= `CFG_RESET;
        else if (ce && wr_ctrl && (f_chan == `CHAN_SEL_CONFIG))
            cfg_q <= f_data[3:0];
    end

    assign clamp_enable             = cfg_q[`CFG_CLAMP_ENABLE];
    assign overtemp_shutdown_enable = cfg_q[`CFG_OVERTEMP_EN];
    assign clear_level_select       = cfg_q[`CFG_CLEAR_SELECT];

    // No-op and unknown channel codes fall through untouched
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            dac_clear <= 1'b0;
            dac_load  <= 1'b0;
        end
        else if (ce)
        begin
            dac_clear <= wr_ctrl && (f_chan == `CHAN_SEL_CLEAR);
            dac_load  <= wr_ctrl && (f_chan == `CHAN_SEL_LOAD);
        end
    end

    // Clear code kind per channel
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_clear
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                    clear_kind[gi] <= quad_dac_ctrl_pkg::CLR_ZERO_VOLT;
                else if (ce)
                begin
                    if (!clear_level_select)
                        clear_kind[gi] <= quad_dac_ctrl_pkg::CLR_ZERO_VOLT;
                    else if (chan_range_bipolar[gi])
                        clear_kind[gi] <= quad_dac_ctrl_pkg::CLR_NEG_FULL;
                    else
                        clear_kind[gi] <= quad_dac_ctrl_pkg::CLR_MIDSCALE;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Power and alert register
    logic [CHANNELS-1:0] pu_q;
    logic                ref_pu_q;
    logic                ot_alert_q;
    logic [CHANNELS-1:0] oc_alert_q;
    logic                ot_event;
    assign ot_event = ot_now && overtemp_shutdown_enable;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ref_pu_q <= 1'b0;
        else if (ce && wr_power)
            ref_pu_q <= f_data[`PWR_REF_PU];
    end

    // Alert is read-only; it drops once the host rewrites power with no overtemp
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ot_alert_q <= 1'b0;
        else if (ce)
        begin
            if (ot_event)
                ot_alert_q <= 1'b1;
            else if (wr_power)
                ot_alert_q <= 1'b0;
        end
    end

    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_chan
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                    pu_q[gi] <= 1'b0;
                else if (ce)
                begin
                    if (ot_event)
                        pu_q[gi] <= 1'b0;
                    else if (oc_q[gi] && !clamp_enable)
                        pu_q[gi] <= 1'b0;
                    else if (wr_power)
                        pu_q[gi] <= f_data[`PWR_CHAN_PU_LO + gi];
                    else if (ot_alert_q)
                        pu_q[gi] <= 1'b0;
                end
            end

            // Fault set wins over any clear
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                    oc_alert_q[gi] <= 1'b0;
                else if (ce)
                begin
                    if (oc_q[gi])
                        oc_alert_q[gi] <= 1'b1;
                    else if (clamp_enable)
                        oc_alert_q[gi] <= 1'b0;
                    else if (wr_power)
                        oc_alert_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    assign chan_power_up      = pu_q;
    assign reference_power_up = ref_pu_q;

    // ==========================================================
    // Readback
    logic [15:0]            rd_word;
    logic [`FRAME_BITS-1:0] tx_q;
    always_comb
    begin
        rd_word = 16'h0000;
        if (f_reg == `REG_SEL_POWER)
        begin
            rd_word[`PWR_CHAN_PU_LO +: 4] = pu_q[3:0];
            rd_word[`PWR_REF_PU]          = ref_pu_q;
            rd_word[`PWR_OVERTEMP]        = ot_alert_q;
            rd_word[`PWR_OC_LO +: 4]      = oc_alert_q[3:0];
        end
        else if ((f_reg == `REG_SEL_CONTROL) && (f_chan == `CHAN_SEL_CONFIG))
            rd_word[3:0] = cfg_q;
    end
    // Read request loads; next frame shifts on rises, none after the last fall
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            tx_q <= '0;
        else if (ce)
        begin
            if (frame_done && f_read)
                tx_q <= {frame[`FRAME_BITS-1:16], rd_word};
            else if (frame_done)
                tx_q <= '0;
            else if ((fr_q == quad_dac_ctrl_pkg::FR_SHIFT) && sync_low && sclk_rise
                     && (bit_cnt_q != '0))
                tx_q <= {tx_q[`FRAME_BITS-2:0], 1'b0};
        end
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            sdo <= 1'b0;
        else if (ce)
            sdo <= tx_q[`FRAME_BITS-1];
    end
    assign sdo_oe = ~cfg_q[`CFG_SDO_DISABLE];
endmodule : quad_dac_ctrl
`default_nettype wire

// File: core/quad_dac_ctrl_map.svh
// Serial frame layout, register codes, field positions and reset values
`ifndef QUAD_DAC_CTRL_MAP_SVH
`define QUAD_DAC_CTRL_MAP_SVH

// ==========================================================
// Serial frame
`define FRAME_BITS          24
`define FRAME_CNT_W         5
`define FRAME_RW_BIT        23
`define FRAME_REG_HI        21
`define FRAME_REG_LO        19
`define FRAME_CHAN_HI       18
`define FRAME_CHAN_LO       16
`define FRAME_DATA_HI       15

// ==========================================================
// Register select and channel select codes
`define REG_SEL_POWER       3'h2
`define REG_SEL_CONTROL     3'h3
`define CHAN_SEL_NOP        3'h0
`define CHAN_SEL_CONFIG     3'h1
`define CHAN_SEL_CLEAR      3'h4
`define CHAN_SEL_LOAD       3'h5

// ==========================================================
// Control configuration fields
`define CFG_SDO_DISABLE     0
`define CFG_CLEAR_SELECT    1
`define CFG_CLAMP_ENABLE    2
`define CFG_OVERTEMP_EN     3
`define CFG_RESET           4'h4

// ==========================================================
// Power and alert status fields
`define PWR_CHAN_PU_LO      0
`define PWR_REF_PU          4
`define PWR_OVERTEMP        5
`define PWR_OC_LO           7
`define PWR_CHAN_PU_RESET   4'h0

`endif

// File: core/quad_dac_ctrl_pkg.sv
// Types shared by the quad converter control block
package quad_dac_ctrl_pkg;

    // Kind of clear code a channel receives
    typedef enum logic [1:0] {
        CLR_ZERO_VOLT = 2'h0,
        CLR_MIDSCALE  = 2'h1,
        CLR_NEG_FULL  = 2'h2
    } clear_kind_t;

    // Serial frame tracking, one-hot
    typedef enum logic [2:0] {
        FR_IDLE  = 3'h1,
        FR_SHIFT = 3'h2,
        FR_DONE  = 3'h4
    } frame_state_t;

endpackage : quad_dac_ctrl_pkg

// File: bench/quad_dac_ctrl_chk.sv
// Port-level assertions for the quad converter control block
`timescale 1ns/100ps
`default_nettype none
module quad_dac_ctrl_chk #(
    parameter int CHANNELS = 4
) (
    // Clock and reset
    input wire logic                           mclk,
    input wire logic                           rst_n,
    input wire logic                           ce,
    // Serial link
    input wire logic                           sclk,
    input wire logic                           sync_n,
    input wire logic                           sdin,
    input wire logic                           sdo,
    input wire logic                           sdo_oe,
    // Faults and ranges
    input wire logic [CHANNELS-1:0]            overcurrent_in,
    input wire logic                           overtemp_in,
    input wire logic [CHANNELS-1:0]            chan_range_bipolar,
    // Converter controls
    input wire logic                           dac_clear,
    input wire logic                           dac_load,
    input wire quad_dac_ctrl_pkg::clear_kind_t clear_kind [CHANNELS],
    input wire logic [CHANNELS-1:0]            chan_power_up,
    input wire logic                           reference_power_up,
    input wire logic                           clamp_enable,
    input wire logic                           overtemp_shutdown_enable,
    input wire logic                           clear_level_select
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // ====================
    // Properties
    property p_reset;
        $rose(rst_n) |-> chan_power_up == '0 && !reference_power_up && clamp_enable
            && !overtemp_shutdown_enable && sdo_oe;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset state");
    property p_clr_pulse;
        dac_clear |=> !dac_clear;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clear too long");
    property p_ld_pulse;
        dac_load |=> !dac_load;
    endproperty
    a_ld_pulse: assert property (p_ld_pulse) else $error("load too long");
    property p_clr_frame;
        dac_clear || dac_load |-> !$past(sync_n, 4);
    endproperty
    a_clr_frame: assert property (p_clr_frame) else $error("pulse outside frame");
    property p_kind_zero;
        !clear_level_select && !$past(clear_level_select)
            |-> clear_kind[0] == quad_dac_ctrl_pkg::CLR_ZERO_VOLT;
    endproperty
    a_kind_zero: assert property (p_kind_zero) else $error("clear kind not zero");
    property p_kind_range;
        clear_level_select && $past(clear_level_select) && $stable(chan_range_bipolar)
            |-> clear_kind[1] == (chan_range_bipolar[1] ? quad_dac_ctrl_pkg::CLR_NEG_FULL
            : quad_dac_ctrl_pkg::CLR_MIDSCALE);
    endproperty
    a_kind_range: assert property (p_kind_range) else $error("clear kind wrong");
    property p_overtemp;
        overtemp_shutdown_enable && overtemp_in |-> ##[0:6] chan_power_up == '0;
    endproperty
    a_overtemp: assert property (p_overtemp) else $error("no thermal shutdown");
    property p_auto_pd;
        (!clamp_enable && overcurrent_in[2])[*4] |=> !chan_power_up[2];
    endproperty
    a_auto_pd: assert property (p_auto_pd) else $error("no auto power-down");
    property p_clamp;
        (clamp_enable && !overtemp_shutdown_enable && sync_n)[*8] |-> $stable(chan_power_up);
    endproperty
    a_clamp: assert property (p_clamp) else $error("power changed in clamp");
endmodule : quad_dac_ctrl_chk

bind quad_dac_ctrl quad_dac_ctrl_chk #(.CHANNELS(CHANNELS)) quad_dac_ctrl_chk_i (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
    .sdo(sdo), .sdo_oe(sdo_oe), .overcurrent_in(overcurrent_in),
    .overtemp_in(overtemp_in), .chan_range_bipolar(chan_range_bipolar),
    .dac_clear(dac_clear), .dac_load(dac_load), .clear_kind(clear_kind),
    .chan_power_up(chan_power_up), .reference_power_up(reference_power_up),
    .clamp_enable(clamp_enable), .overtemp_shutdown_enable(overtemp_shutdown_enable),
    .clear_level_select(clear_level_select)
);
`default_nettype wire

// File: bench/serial_host.sv
// Serial host model sending 24-bit frames
`timescale 1ns/100ps
`default_nettype none
module serial_host (
    // Clock
    input  wire logic mclk,
    // Serial link
    output var logic  sclk,
    output var logic  sync_n,
    output var logic  sdin,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    logic line_q;
    // Released line shows inverse of last level
    wire  sdo_line = sdo_oe ? sdo : ~line_q;

    initial
    begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdin = 1'b0;
    end

    always @(posedge mclk)
        if (sdo_oe)
            line_q <= sdo;

    // ====================
    // One frame, MSB first
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        sync_n <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sdin <= w[i];
            repeat (4) @(posedge mclk);
            sclk <= 1'b0;
            repeat (4) @(posedge mclk);
            r[i] = sdo_line;
            sclk <= 1'b1;
        end
        repeat (4) @(posedge mclk);
        sync_n <= 1'b1;
        sdin <= ~w[0];
        repeat (8) @(posedge mclk);
    endtask : xfer
endmodule : serial_host
`default_nettype wire

// File: bench/test_quad_dac_ctrl.sv
// Self-checking bench for the quad converter control block
`timescale 1ns/100ps
`default_nettype none
module test_quad_dac_ctrl;
    logic       mclk, rst_n, ce, overtemp_in, sdo, sdo_oe, dac_clear, dac_load;
    logic [3:0] overcurrent_in, chan_range_bipolar, chan_power_up;
    logic       reference_power_up, clamp_enable, overtemp_shutdown_enable;
    logic       clear_level_select;
    wire logic  sclk, sync_n, sdin;
    int         miscompares = 0, n_compared = 0, n_clr = 0, n_ld = 0;
    quad_dac_ctrl_pkg::clear_kind_t clear_kind [4];

    quad_dac_ctrl quad_dac_ctrl_i (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
        .sdo(sdo), .sdo_oe(sdo_oe), .overcurrent_in(overcurrent_in),
        .overtemp_in(overtemp_in), .chan_range_bipolar(chan_range_bipolar),
        .dac_clear(dac_clear), .dac_load(dac_load), .clear_kind(clear_kind),
        .chan_power_up(chan_power_up), .reference_power_up(reference_power_up),
        .clamp_enable(clamp_enable), .overtemp_shutdown_enable(overtemp_shutdown_enable),
        .clear_level_select(clear_level_select));
    serial_host serial_host_i (.mclk(mclk), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
        .sdo(sdo), .sdo_oe(sdo_oe));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        n_clr <= n_clr + dac_clear;
        n_ld <= n_ld + dac_load;
    end

    // ====================
    // Tasks
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [23:0] w);
        logic [23:0] r;
        serial_host_i.xfer(w, r);
    endtask : wr

    task automatic rd(input logic [7:0] h, input logic [15:0] e);
        logic [23:0] r;
        serial_host_i.xfer({h, 16'h0000}, r);
        serial_host_i.xfer(24'h180000, r);
        chk("readback", {h, e}, r);
    endtask : rd

    task automatic settle;
        repeat (10) @(posedge mclk);
    endtask : settle

    function automatic logic [23:0] pwr;
        return {19'h0, reference_power_up, chan_power_up};
    endfunction : pwr

    function automatic logic [23:0] cfg;
        return {20'h0, overtemp_shutdown_enable, clamp_enable, clear_level_select, ~sdo_oe};
    endfunction : cfg

    function automatic logic [23:0] kinds;
        return {16'h0, clear_kind[3], clear_kind[2], clear_kind[1], clear_kind[0]};
    endfunction : kinds

    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        end_of_test;
    end

    // ====================
    // Tests
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        overtemp_in = 1'b0;
        overcurrent_in = 4'h0;
        chan_range_bipolar = 4'h5;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("power", pwr(), 24'h000000);
        chk("config", cfg(), 24'h000004);
        wr(24'h10001F);
        chk("power", pwr(), 24'h00001F);
        wr(24'h1007FF);
        rd(8'h90, 16'h001F);
        wr(24'h18FFFF);
        chk("power", pwr(), 24'h00001F);
        chk("config", cfg(), 24'h000004);
        wr(24'h1C0000);
        chk("clears", 24'(n_clr), 24'h000001);
        repeat (250) @(posedge mclk);
        wr(24'h1D0000);
        chk("loads", 24'(n_ld + n_clr), 24'h000002);
        wr(24'h19000B);
        chk("config", cfg(), 24'h00000B);
        chk("kinds", kinds(), 24'h000066);
        wr(24'h190008);
        chk("kinds", kinds(), 24'h000000);
        rd(8'h99, 16'h0008);
        overcurrent_in <= 4'h4;
        settle;
        chk("power", pwr(), 24'h00001B);
        rd(8'h90, 16'h021B);
        overcurrent_in <= 4'h0;
        wr(24'h190004);
        overcurrent_in <= 4'h1;
        settle;
        chk("power", pwr(), 24'h00001B);
        rd(8'h90, 16'h009B);
        overcurrent_in <= 4'h0;
        settle;
        rd(8'h90, 16'h001B);
        overtemp_in <= 1'b1;
        settle;
        chk("power", pwr(), 24'h00001B);
        wr(24'h19000C);
        settle;
        chk("chans", 24'(chan_power_up), 24'h000000);
        rd(8'h90, 16'h0030);
        overtemp_in <= 1'b0;
        settle;
        chk("chans", 24'(chan_power_up), 24'h000000);
        wr(24'h10001F);
        chk("power", pwr(), 24'h00001F);
        // Fault while frozen must leave no alert behind
        ce <= 1'b0;
        overcurrent_in <= 4'h8;
        settle;
        overcurrent_in <= 4'h0;
        ce <= 1'b1;
        settle;
        rd(8'h90, 16'h001F);
        end_of_test;
    end
endmodule : test_quad_dac_ctrl
`default_nettype wire
